//--- core/cbs_pkg.sv
`default_nettype none
package cbs_pkg;
	// ==========================================================
	// timing and encodings
	localparam int CBS_ABORT_CLKS = 5;
	localparam logic [3:0] CBS_CMD_SPECIAL = 4'h1;
	localparam logic [31:0] CBS_AD_RST = 32'h0000_0000;
	localparam logic [3:0] CBS_BE_RST = 4'h0;
	localparam logic [3:0] CBS_FLAGS_RST = 4'h0;
	// ==========================================================
	// sticky flag positions
	localparam int CBS_FLG_PERR = 0;
	localparam int CBS_FLG_SERR = 1;
	localparam int CBS_FLG_STS = 2;
	localparam int CBS_FLG_ABORT = 3;
	// ==========================================================
	// positions in the core-side synchroniser vector
	localparam int CBS_SY_IRQ = 0;
	localparam int CBS_SY_STS = 1;
	localparam int CBS_SY_AUD = 2;
	localparam int CBS_SY_DET1 = 3;
	localparam int CBS_SY_DET2 = 4;
	localparam int CBS_SY_VS1 = 5;
	localparam int CBS_SY_VS2 = 6;
	localparam int CBS_SY_SERR = 7;
	localparam int CBS_SY_CRUN = 8;
	localparam int CBS_SY_LOCK = 9;
	localparam int CBS_SY_DONE = 10;
	localparam int CBS_SY_TWR = 11;
	localparam int CBS_SY_PERR = 12;
	localparam int CBS_SY_W = 13;
	// idle pin levels, so the synchronisers leave reset without showing a false event or level
	localparam logic [12:0] CBS_SY_IDLE = 13'h0399;
	// ==========================================================
	// types
	typedef enum logic [1:0] {CBS_RES_OK, CBS_RES_ABORT, CBS_RES_RETRY} cbs_res_t;
	typedef enum logic [2:0] {CBS_IDLE, CBS_IADDR, CBS_IDATA, CBS_IEND, CBS_GRANT, CBS_TDATA, CBS_TEND} cbs_state_t;
	// ==========================================================
	// shared arithmetic
	function automatic logic cbs_even_par(input logic [31:0] ad, input logic [3:0] cbe);
		return ^{ad, cbe};
	endfunction
	function automatic logic cbs_is_write(input logic [3:0] cmd);
		return cmd[0];
	endfunction
endpackage
`default_nettype wire

//--- core/cbs_socket.sv
`default_nettype none
module cbs_socket import cbs_pkg::*; #(
	parameter int SLOT_ID = 0,
	parameter int ABORT_CLKS = CBS_ABORT_CLKS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic init_req,
	input wire logic [3:0] init_cmd,
	input wire logic [31:0] init_addr,
	input wire logic [31:0] init_wdata,
	input wire logic [3:0] init_be,
	input wire logic init_lock,
	output logic init_busy,
	output logic init_done,
	output logic [1:0] init_status,
	output logic [31:0] init_rdata,
	output logic tgt_wr_valid,
	output logic [31:0] tgt_wr_addr,
	output logic [31:0] tgt_wr_data,
	output logic [3:0] tgt_wr_be,
	input wire logic [3:0] flag_clr,
	output logic [3:0] flags,
	input wire logic audio_en,
	input wire logic sock_rst_req,
	input wire logic clk_slow_req,
	output logic card_irq,
	output logic card_present,
	output logic [3:0] card_sense,
	output logic card_clk_req,
	output logic lock_busy,
	output logic wake_event,
	output logic host_serr_n,
	output logic speaker_out,
	input wire logic sock_clk,
	output logic sock_reset_n,
	input wire logic [31:0] sock_addr_data_in,
	output logic [31:0] sock_addr_data_out,
	output logic sock_addr_data_oe,
	input wire logic [3:0] sock_cmd_byte_en_in,
	output logic [3:0] sock_cmd_byte_en_out,
	output logic sock_cmd_byte_en_oe,
	input wire logic sock_parity_in,
	output logic sock_parity_out,
	output logic sock_parity_oe,
	input wire logic sock_parity_err_n_in,
	output logic sock_parity_err_n_out,
	output logic sock_parity_err_oe,
	input wire logic sock_frame_n_in,
	output logic sock_frame_n_out,
	output logic sock_frame_oe,
	input wire logic sock_initiator_ready_n_in,
	output logic sock_initiator_ready_n_out,
	output logic sock_initiator_ready_oe,
	input wire logic sock_target_ready_n_in,
	output logic sock_target_ready_n_out,
	output logic sock_target_ready_oe,
	input wire logic sock_dev_select_n_in,
	output logic sock_dev_select_n_out,
	output logic sock_dev_select_oe,
	input wire logic sock_stop_n_in,
	output logic sock_stop_n_out,
	output logic sock_stop_oe,
	input wire logic sock_lock_n_in,
	output logic sock_lock_n_out,
	output logic sock_lock_oe,
	input wire logic sock_clk_run_n_in,
	output logic sock_clk_run_n_out,
	output logic sock_clk_run_oe,
	input wire logic sock_bus_request_n,
	output logic sock_bus_grant_n,
	input wire logic sock_irq_n,
	input wire logic sock_system_err_n,
	input wire logic sock_status_change,
	input wire logic sock_audio_in,
	input wire logic sock_detect_1_n,
	input wire logic sock_detect_2_n,
	input wire logic sock_volt_sense_1,
	input wire logic sock_volt_sense_2
);
	if (ABORT_CLKS < 1 || ABORT_CLKS > 15) begin : g_chk
		$error("ABORT_CLKS must be 1..15");
	end
	// one instance serves one slot; slots A and B are two instances
	if (SLOT_ID < 0 || SLOT_ID > 1) begin : g_slot
		$error("SLOT_ID must be 0 or 1");
	end

	// ==========================================================
	// core side: command capture and crossings
	logic busy_q, itgl_q, ilock_q, done_q, twv_q, spk_q;
	logic [3:0] icmd_q, ibe_q, flags_q, twbe_o_q;
	logic [31:0] iaddr_q, iwdata_q, rdata_o_q, twa_o_q, twd_o_q;
	logic [1:0] stat_q;
	logic [CBS_SY_W-1:0] c1_q, c2_q, c3_q;
	logic done_tgl_q, twr_tgl_q, perr_tgl_q;
	cbs_res_t res_q;
	logic [31:0] rdata_q, twr_data_q, taddr_q;
	logic [3:0] twr_be_q;

	wire [CBS_SY_W-1:0] sy_raw = {perr_tgl_q, twr_tgl_q, done_tgl_q, sock_lock_n_in, sock_clk_run_n_in,
		sock_system_err_n, sock_volt_sense_2, sock_volt_sense_1, sock_detect_2_n, sock_detect_1_n,
		sock_audio_in, sock_status_change, sock_irq_n};
	wire [CBS_SY_W-1:0] tog = c2_q ^ c3_q;
	wire done_ev = tog[CBS_SY_DONE];
	wire twr_ev = tog[CBS_SY_TWR];
	wire serr_ev = c3_q[CBS_SY_SERR] & ~c2_q[CBS_SY_SERR];
	wire sts_ev = c2_q[CBS_SY_STS] & ~c3_q[CBS_SY_STS];
	wire abort_ev = done_ev & (res_q == CBS_RES_ABORT);
	wire [3:0] flag_set = {abort_ev, sts_ev, serr_ev, tog[CBS_SY_PERR]};
	wire start = init_req & ~busy_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			c1_q <= CBS_SY_IDLE;
			c2_q <= CBS_SY_IDLE;
			c3_q <= CBS_SY_IDLE;
		end else begin
			c1_q <= sy_raw;
			c2_q <= c1_q;
			c3_q <= c2_q;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
			itgl_q <= 1'b0;
			icmd_q <= CBS_BE_RST;
			ibe_q <= CBS_BE_RST;
			iaddr_q <= CBS_AD_RST;
			iwdata_q <= CBS_AD_RST;
			ilock_q <= 1'b0;
		end else if (start) begin
			busy_q <= 1'b1;
			itgl_q <= ~itgl_q;
			icmd_q <= init_cmd;
			ibe_q <= init_be;
			iaddr_q <= init_addr;
			iwdata_q <= init_wdata;
			ilock_q <= init_lock;
		end else if (done_ev) begin
			busy_q <= 1'b0;
		end
	end

	// result and target words are quasi-static in the socket domain once the toggle lands
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_q <= 1'b0;
			stat_q <= 2'h0;
			rdata_o_q <= CBS_AD_RST;
			twv_q <= 1'b0;
			twa_o_q <= CBS_AD_RST;
			twd_o_q <= CBS_AD_RST;
			twbe_o_q <= CBS_BE_RST;
		end else begin
			done_q <= done_ev;
			twv_q <= twr_ev;
			if (done_ev) begin
				stat_q <= res_q;
				rdata_o_q <= rdata_q;
			end
			if (twr_ev) begin
				twa_o_q <= taddr_q;
				twd_o_q <= twr_data_q;
				twbe_o_q <= twr_be_q;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= CBS_FLAGS_RST;
			spk_q <= 1'b0;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
			spk_q <= audio_en & c2_q[CBS_SY_AUD];
		end
	end

	assign init_busy = busy_q;
	assign init_done = done_q;
	assign init_status = stat_q;
	assign init_rdata = rdata_o_q;
	assign tgt_wr_valid = twv_q;
	assign tgt_wr_addr = twa_o_q;
	assign tgt_wr_data = twd_o_q;
	assign tgt_wr_be = twbe_o_q;
	assign flags = flags_q;
	assign speaker_out = spk_q;
	assign card_irq = ~c3_q[CBS_SY_IRQ];
	assign card_present = ~c3_q[CBS_SY_DET1] & ~c3_q[CBS_SY_DET2];
	assign card_sense = {c3_q[CBS_SY_VS2], c3_q[CBS_SY_VS1], c3_q[CBS_SY_DET2], c3_q[CBS_SY_DET1]};
	assign card_clk_req = ~c3_q[CBS_SY_CRUN];
	assign lock_busy = ~c3_q[CBS_SY_LOCK];
	assign wake_event = flags_q[CBS_FLG_STS];
	assign host_serr_n = ~flags_q[CBS_FLG_SERR];

	// ==========================================================
	// socket side: reset release and control crossings
	logic srst_m_q, srst_q, srstn_q;
	logic [2:0] s1_q, s2_q;
	logic is3_q, pend_q;

	always_ff @(posedge sock_clk or negedge rst_b) begin
		if (!rst_b) begin
			srst_m_q <= 1'b0;
			srst_q <= 1'b0;
		end else begin
			srst_m_q <= 1'b1;
			srst_q <= srst_m_q;
		end
	end

	always_ff @(posedge sock_clk or negedge srst_q) begin
		if (!srst_q) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			is3_q <= 1'b0;
			srstn_q <= 1'b0;
		end else begin
			s1_q <= {clk_slow_req, sock_rst_req, itgl_q};
			s2_q <= s1_q;
			is3_q <= s2_q[0];
			srstn_q <= ~s2_q[1];
		end
	end

	assign sock_reset_n = srstn_q;
	assign sock_clk_run_n_out = 1'b1;
	assign sock_clk_run_oe = s2_q[2];

	// ==========================================================
	// socket side: bus sequencer
	cbs_state_t st_q;
	logic [31:0] ad_q;
	logic [3:0] cbe_q, tcmd_q, cnt_q;
	logic ad_oe_q, cbe_oe_q, frame_q, irdy_q, ini_oe_q;
	logic devsel_q, trdy_q, stop_q, tgt_oe_q, lock_q, lock_oe_q, gnt_q;
	logic par_q, par_oe_q, chk_q, calc_q, perr_q, perr_oe_q;

	wire ireq_ev = s2_q[0] ^ is3_q;
	wire card_rst = ~srstn_q;
	wire foreign_lock = ~sock_lock_n_in & ~lock_oe_q;
	wire dphase = ~sock_initiator_ready_n_in & ~sock_target_ready_n_in;
	wire ini_wr = cbs_is_write(icmd_q);
	wire tgt_wr = cbs_is_write(tcmd_q);
	wire tgt_addr = (st_q == CBS_GRANT) & ~sock_frame_n_in;
	wire claim = sock_cmd_byte_en_in != CBS_CMD_SPECIAL;
	wire timeout = sock_dev_select_n_in & (cnt_q == 4'(ABORT_CLKS - 1));
	wire [3:0] par_cbe = cbe_oe_q ? cbe_q : sock_cmd_byte_en_in;
	wire chk_d = tgt_addr | ((st_q == CBS_TDATA) & tgt_wr & dphase) | ((st_q == CBS_IDATA) & ~ini_wr & dphase);
	wire spec_d = tgt_addr ? ~claim : ((st_q == CBS_TDATA) & (tcmd_q == CBS_CMD_SPECIAL));
	wire perr_hit = chk_q & (sock_parity_in != calc_q);

	always_ff @(posedge sock_clk or negedge srst_q) begin
		if (!srst_q) begin
			par_q <= 1'b0;
			par_oe_q <= 1'b0;
			chk_q <= 1'b0;
			calc_q <= 1'b0;
			perr_q <= 1'b1;
			perr_oe_q <= 1'b0;
			perr_tgl_q <= 1'b0;
		end else begin
			par_q <= cbs_even_par(ad_q, par_cbe);
			par_oe_q <= ad_oe_q;
			chk_q <= chk_d & ~spec_d;
			calc_q <= cbs_even_par(sock_addr_data_in, sock_cmd_byte_en_in);
			perr_q <= ~perr_hit;
			perr_oe_q <= perr_hit;
			if (perr_hit)
				perr_tgl_q <= ~perr_tgl_q;
		end
	end

	always_ff @(posedge sock_clk or negedge srst_q) begin
		if (!srst_q) begin
			st_q <= CBS_IDLE;
			pend_q <= 1'b0;
			ad_q <= CBS_AD_RST;
			cbe_q <= CBS_BE_RST;
			ad_oe_q <= 1'b1;
			cbe_oe_q <= 1'b1;
			frame_q <= 1'b1;
			irdy_q <= 1'b1;
			ini_oe_q <= 1'b1;
			devsel_q <= 1'b1;
			trdy_q <= 1'b1;
			stop_q <= 1'b1;
			tgt_oe_q <= 1'b1;
			lock_q <= 1'b1;
			lock_oe_q <= 1'b0;
			gnt_q <= 1'b1;
			cnt_q <= 4'h0;
			res_q <= CBS_RES_OK;
			rdata_q <= CBS_AD_RST;
			tcmd_q <= CBS_BE_RST;
			taddr_q <= CBS_AD_RST;
			twr_data_q <= CBS_AD_RST;
			twr_be_q <= CBS_BE_RST;
			done_tgl_q <= 1'b0;
			twr_tgl_q <= 1'b0;
		end else begin
			if (ireq_ev)
				pend_q <= 1'b1;
			unique case (st_q)
				CBS_IDLE: begin
					// in socket reset the frame, ready, select, stop, address/data and command lines are held at a valid idle level
					frame_q <= 1'b1;
					irdy_q <= 1'b1;
					devsel_q <= 1'b1;
					trdy_q <= 1'b1;
					stop_q <= 1'b1;
					ad_q <= CBS_AD_RST;
					cbe_q <= CBS_BE_RST;
					ini_oe_q <= card_rst;
					tgt_oe_q <= card_rst;
					ad_oe_q <= card_rst;
					cbe_oe_q <= card_rst;
					if (!card_rst && pend_q && !foreign_lock) begin
						pend_q <= 1'b0;
						ad_q <= iaddr_q;
						cbe_q <= icmd_q;
						ad_oe_q <= 1'b1;
						cbe_oe_q <= 1'b1;
						frame_q <= 1'b0;
						ini_oe_q <= 1'b1;
						st_q <= CBS_IADDR;
					end else if (!card_rst && !sock_bus_request_n) begin
						gnt_q <= 1'b0;
						st_q <= CBS_GRANT;
					end
				end
				CBS_IADDR: begin
					frame_q <= 1'b1;
					irdy_q <= 1'b0;
					ad_q <= iwdata_q;
					ad_oe_q <= ini_wr;
					cbe_q <= ibe_q;
					lock_q <= ~ilock_q;
					lock_oe_q <= ilock_q;
					cnt_q <= 4'h0;
					st_q <= CBS_IDATA;
				end
				CBS_IDATA: begin
					if (dphase) begin
						rdata_q <= sock_addr_data_in;
						res_q <= CBS_RES_OK;
						st_q <= CBS_IEND;
					end else if (!sock_stop_n_in) begin
						res_q <= CBS_RES_RETRY;
						st_q <= CBS_IEND;
					end else if (timeout) begin
						res_q <= CBS_RES_ABORT;
						st_q <= CBS_IEND;
					end else if (sock_dev_select_n_in) begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				CBS_IEND: begin
					irdy_q <= 1'b1;
					ad_oe_q <= 1'b0;
					cbe_oe_q <= 1'b0;
					lock_q <= 1'b1;
					lock_oe_q <= 1'b0;
					done_tgl_q <= ~done_tgl_q;
					st_q <= CBS_IDLE;
				end
				CBS_GRANT: begin
					if (tgt_addr) begin
						gnt_q <= 1'b1;
						tcmd_q <= sock_cmd_byte_en_in;
						taddr_q <= sock_addr_data_in;
						devsel_q <= ~claim;
						stop_q <= ~claim;
						trdy_q <= ~claim | ~cbs_is_write(sock_cmd_byte_en_in);
						tgt_oe_q <= claim;
						st_q <= claim ? CBS_TDATA : CBS_TEND;
					end else if (sock_bus_request_n) begin
						gnt_q <= 1'b1;
						st_q <= CBS_IDLE;
					end
				end
				CBS_TDATA: begin
					// reads get one turnaround cycle before the device drives data
					if (!tgt_wr && !ad_oe_q) begin
						ad_q <= twr_data_q;
						ad_oe_q <= 1'b1;
						trdy_q <= 1'b0;
					end else if (dphase) begin
						if (tgt_wr) begin
							twr_data_q <= sock_addr_data_in;
							twr_be_q <= sock_cmd_byte_en_in;
							twr_tgl_q <= ~twr_tgl_q;
						end
						devsel_q <= 1'b1;
						trdy_q <= 1'b1;
						stop_q <= 1'b1;
						ad_oe_q <= 1'b0;
						st_q <= CBS_TEND;
					end
				end
				CBS_TEND: begin
					tgt_oe_q <= 1'b0;
					st_q <= CBS_IDLE;
				end
			endcase
		end
	end

	assign sock_addr_data_out = ad_q;
	assign sock_addr_data_oe = ad_oe_q;
	assign sock_cmd_byte_en_out = cbe_q;
	assign sock_cmd_byte_en_oe = cbe_oe_q;
	assign sock_parity_out = par_q;
	assign sock_parity_oe = par_oe_q;
	assign sock_parity_err_n_out = perr_q;
	assign sock_parity_err_oe = perr_oe_q;
	assign sock_frame_n_out = frame_q;
	assign sock_frame_oe = ini_oe_q;
	assign sock_initiator_ready_n_out = irdy_q;
	assign sock_initiator_ready_oe = ini_oe_q;
	assign sock_dev_select_n_out = devsel_q;
	assign sock_dev_select_oe = tgt_oe_q;
	assign sock_target_ready_n_out = trdy_q;
	assign sock_target_ready_oe = tgt_oe_q;
	assign sock_stop_n_out = stop_q;
	assign sock_stop_oe = tgt_oe_q;
	assign sock_lock_n_out = lock_q;
	assign sock_lock_oe = lock_oe_q;
	assign sock_bus_grant_n = gnt_q;

	// ==========================================================
	// checks
	sequence s_bad_data;
		chk_d && !spec_d ##1 (sock_parity_in != $past(^{sock_addr_data_in, sock_cmd_byte_en_in}));
	endsequence
	par_delay_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		ad_oe_q |=> par_oe_q && (par_q == ^{$past(ad_q), $past(par_cbe)}))
		else $error("parity not driven one clock after its data");
	perr_two_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		s_bad_data |=> perr_oe_q && !perr_q)
		else $error("parity error not driven two clocks after data");
	frame_last_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		st_q == CBS_IADDR |-> !frame_q ##1 frame_q && !irdy_q)
		else $error("frame not released for the final data phase");
	complete_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		(st_q == CBS_IDATA) && !dphase && sock_stop_n_in && !timeout |=> st_q != CBS_IEND)
		else $error("data phase ended without both ready lines");
	abort_time_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		(st_q == CBS_IDATA) && timeout && !dphase && sock_stop_n_in |=> (st_q == CBS_IEND)
		&& (res_q == CBS_RES_ABORT) ##1 done_tgl_q != $past(done_tgl_q))
		else $error("unclaimed cycle not aborted on time");
	claim_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		tgt_addr && claim |=> !devsel_q && tgt_oe_q && !stop_q)
		else $error("cycle aimed at device not claimed");
	grant_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		$fell(gnt_q) |-> $past(st_q) == CBS_IDLE && !$past(pend_q && !foreign_lock))
		else $error("grant given during a transaction");
	reset_hold_a: assert property (@(posedge sock_clk) disable iff (!srst_q)
		card_rst && st_q == CBS_IDLE |=> ini_oe_q && frame_q && irdy_q && tgt_oe_q)
		else $error("lines not held valid in socket reset");
	sticky_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		serr_ev |=> flags_q[CBS_FLG_SERR] && !host_serr_n)
		else $error("system error not latched");
	speaker_a: assert property (@(posedge core_clk) disable iff (!rst_b)
		audio_en && $stable(audio_en) |-> ##1 speaker_out == $past(c2_q[CBS_SY_AUD]))
		else $error("audio not passed to speaker");
endmodule // cbs_socket
`default_nettype wire

//--- bench/cbs_card.sv
`default_nettype none
module cbs_card import cbs_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe,
	input wire logic par,
	input wire logic dpe,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic perr_n,
	input wire logic gnt_n,
	output logic [31:0] ad_o,
	output logic [3:0] cbe_o,
	output logic ad_e,
	output logic cbe_e,
	output logic par_o,
	output logic par_e,
	output logic frm_o,
	output logic irdy_o,
	output logic i_e,
	output logic dev_o,
	output logic trdy_o,
	output logic t_e,
	output logic req_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// knobs set by the bench and results it reads back
	logic claim = 1'b1, retry = 1'b0, bad = 1'b0, pd = 1'b0;
	logic [31:0] rdat = 32'h0, iadr = 32'h0, idat = 32'h0, gadr, gdat;
	logic [3:0] ibe = 4'h0, gcmd, gbe;
	int ngo = 0, ndone = 0, pbad = 0, perr = 0, st = 0;
	initial begin
		{ad_e, cbe_e, par_e, i_e, t_e} = 5'h00;
		{frm_o, irdy_o, dev_o, trdy_o, req_n} = 5'h1F;
		{ad_o, cbe_o, par_o} = 37'h0;
	end
	// ==========================================================
	// card as target and as initiator, one data phase each
	always @(posedge clk) begin
		par_e <= ad_e;
		par_o <= ^{ad, cbe} ^ bad;
		if (dpe === 1'b1 && par !== pd)
			pbad <= pbad + 1;
		pd <= ^{ad, cbe};
		if (perr_n === 1'b0)
			perr <= perr + 1;
		req_n <= !(ngo != ndone && st < 3);
		if (rst_n !== 1'b1) begin
			{ad_e, cbe_e, i_e, t_e} <= 4'h0;
			st <= 0;
		end else case (st)
			0: if (frame_n === 1'b0 && !i_e && claim) begin
				gadr <= ad;
				gcmd <= cbe;
				{dev_o, trdy_o, t_e} <= {1'b0, retry, 1'b1};
				ad_o <= rdat;
				ad_e <= !cbe[0];
				st <= 1;
			end else if (gnt_n === 1'b0 && ngo != ndone && frame_n === 1'b1) begin
				{frm_o, irdy_o, i_e, ad_e, cbe_e} <= 5'h0F;
				{ad_o, cbe_o} <= {iadr, 4'h7};
				st <= 3;
			end
			1: if (irdy_n === 1'b0 && (trdy_n === 1'b0 || retry)) begin
				{gdat, gbe} <= {ad, cbe};
				{dev_o, trdy_o, ad_e} <= 3'h6;
				st <= 2;
			end
			2: {t_e, st} <= {1'b0, 32'h0};
			3: begin
				{frm_o, irdy_o} <= 2'h2;
				{ad_o, cbe_o} <= {idat, ibe};
				st <= 4;
			end
			4: if (trdy_n === 1'b0 && irdy_n === 1'b0) begin
				{irdy_o, ad_e, cbe_e} <= 3'h4;
				ndone <= ndone + 1;
				st <= 5;
			end
			default: {i_e, st} <= {1'b0, 32'h0};
		endcase
	end
endmodule // cbs_card
`default_nettype wire

//--- bench/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cbs_pkg::*;
	logic core_clk = 0, sock_clk = 0, rst_b = 0, lk = 0;
	logic init_req = 0, init_lock = 0, audio_en = 0, sock_rst_req = 0, clk_slow_req = 0;
	logic [3:0] init_cmd = 4'h0, init_be = 4'h0, flag_clr = 4'h0;
	logic [31:0] init_addr = 32'h0, init_wdata = 32'h0;
	logic irq_n = 1, serr_n = 1, sts = 0, aud = 0, det1 = 1, det2 = 1, vs1 = 0, vs2 = 0, crun = 1;
	logic init_busy, init_done, tgt_wr_valid, card_irq, card_present, card_clk_req, lock_busy;
	logic wake_event, host_serr_n, speaker_out, sock_reset_n, gnt_n, req_n, par_l;
	logic [1:0] init_status;
	logic [3:0] flags, card_sense, tgt_wr_be, d_cbo, c_cbo, cbe_w, cbe_l;
	logic [31:0] init_rdata, tgt_wr_addr, tgt_wr_data, d_ado, c_ado, ad_w, ad_l;
	logic d_ade, d_cbe, d_po, d_pe, d_eo, d_ee, d_fo, d_fe, d_io, d_ie, d_to, d_te, d_vo, d_ve;
	logic d_so, d_se, d_lo, d_le, d_co, d_ce, c_ade, c_cbe, c_po, c_pe, c_fo, c_io, c_ie, c_vo, c_to, c_te;
	int err_count = 0, num_checks = 0;
	// ==========================================================
	// wire levels: released data lines flip so a stale value never passes, controls are pulled up except clock run, which falls back to crun
	assign ad_w = d_ade ? d_ado : c_ade ? c_ado : ~ad_l;
	assign cbe_w = d_cbe ? d_cbo : c_cbe ? c_cbo : ~cbe_l;
	wire par_w = d_pe ? d_po : c_pe ? c_po : ~par_l;
	wire frm_w = d_fe ? d_fo : !c_ie | c_fo;
	wire irdy_w = d_ie ? d_io : !c_ie | c_io;
	wire trdy_w = d_te ? d_to : !c_te | c_to;
	wire dev_w = d_ve ? d_vo : !c_te | c_vo;
	wire stop_w = d_se ? d_so : !c_te | c_vo;
	wire perr_w = !d_ee | d_eo;
	wire lock_w = !d_le | d_lo;
	wire crun_w = d_ce ? d_co : crun;
	always @(posedge sock_clk) {ad_l, cbe_l, par_l} <= {ad_w, cbe_w, par_w};
	always @(posedge sock_clk) if (lock_w === 1'b0) lk <= 1'b1;
	always #10 core_clk = ~core_clk;
	initial begin
		#7;
		forever #24 sock_clk = ~sock_clk;
	end
	cbs_socket #(.SLOT_ID(0), .ABORT_CLKS(3)) dut (
		.core_clk, .rst_b, .init_req, .init_cmd, .init_addr, .init_wdata, .init_be, .init_lock, .init_busy,
		.init_done, .init_status, .init_rdata, .tgt_wr_valid, .tgt_wr_addr, .tgt_wr_data, .tgt_wr_be,
		.flag_clr, .flags, .audio_en, .sock_rst_req, .clk_slow_req, .card_irq, .card_present, .card_sense,
		.card_clk_req, .lock_busy, .wake_event, .host_serr_n, .speaker_out, .sock_clk, .sock_reset_n,
		.sock_addr_data_in(ad_w), .sock_addr_data_out(d_ado), .sock_addr_data_oe(d_ade),
		.sock_cmd_byte_en_in(cbe_w), .sock_cmd_byte_en_out(d_cbo), .sock_cmd_byte_en_oe(d_cbe),
		.sock_parity_in(par_w), .sock_parity_out(d_po), .sock_parity_oe(d_pe),
		.sock_parity_err_n_in(perr_w), .sock_parity_err_n_out(d_eo), .sock_parity_err_oe(d_ee),
		.sock_frame_n_in(frm_w), .sock_frame_n_out(d_fo), .sock_frame_oe(d_fe),
		.sock_initiator_ready_n_in(irdy_w), .sock_initiator_ready_n_out(d_io), .sock_initiator_ready_oe(d_ie),
		.sock_target_ready_n_in(trdy_w), .sock_target_ready_n_out(d_to), .sock_target_ready_oe(d_te),
		.sock_dev_select_n_in(dev_w), .sock_dev_select_n_out(d_vo), .sock_dev_select_oe(d_ve),
		.sock_stop_n_in(stop_w), .sock_stop_n_out(d_so), .sock_stop_oe(d_se),
		.sock_lock_n_in(lock_w), .sock_lock_n_out(d_lo), .sock_lock_oe(d_le),
		.sock_clk_run_n_in(crun_w), .sock_clk_run_n_out(d_co), .sock_clk_run_oe(d_ce),
		.sock_bus_request_n(req_n), .sock_bus_grant_n(gnt_n), .sock_irq_n(irq_n), .sock_system_err_n(serr_n),
		.sock_status_change(sts), .sock_audio_in(aud), .sock_detect_1_n(det1), .sock_detect_2_n(det2),
		.sock_volt_sense_1(vs1), .sock_volt_sense_2(vs2));
	cbs_card card (.clk(sock_clk), .rst_n(sock_reset_n), .ad(ad_w), .cbe(cbe_w), .par(par_w), .dpe(d_pe),
		.frame_n(frm_w), .irdy_n(irdy_w), .trdy_n(trdy_w), .perr_n(perr_w), .gnt_n(gnt_n), .ad_o(c_ado),
		.cbe_o(c_cbo), .ad_e(c_ade), .cbe_e(c_cbe), .par_o(c_po), .par_e(c_pe), .frm_o(c_fo), .irdy_o(c_io),
		.i_e(c_ie), .dev_o(c_vo), .trdy_o(c_to), .t_e(c_te), .req_n(req_n));
	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		int i;
		@(negedge core_clk);
		{init_req, init_cmd, init_addr, init_wdata, init_be} = {1'b1, cmd, a, d, be};
		@(negedge core_clk);
		init_req = 0;
		for (i = 0; i < 300 && init_done !== 1'b1; i++)
			@(negedge core_clk);
		chk(i < 300, 1);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_write();
		init_lock = 1;
		xfer(4'h7, 32'h1234_5678, 32'hA5C3_0F96, 4'hA);
		init_lock = 0;
		chk(init_status, CBS_RES_OK);
		chk(card.gadr, 32'h1234_5678);
		chk(card.gcmd, 4'h7);
		chk(card.gdat, 32'hA5C3_0F96);
		chk(card.gbe, 4'hA);
		chk(card.pbad, 0);
		chk(lk, 1);
		$display("test initiator write done");
	endtask
	task automatic t_read();
		card.rdat = 32'h5A3C_9612;
		xfer(4'h6, 32'h0000_0040, 32'h0, 4'hF);
		chk(init_status, CBS_RES_OK);
		chk(init_rdata, 32'h5A3C_9612);
		chk(card.gcmd, 4'h6);
		chk(flags, CBS_FLAGS_RST);
		$display("test initiator read done");
	endtask
	task automatic t_fail(input logic ab);
		{card.claim, card.retry} = {!ab, !ab};
		xfer(4'h7, 32'h0000_0080, 32'h0000_0001, 4'h1);
		{card.claim, card.retry} = 2'b10;
		chk(init_status, ab ? CBS_RES_ABORT : CBS_RES_RETRY);
		chk(flags[CBS_FLG_ABORT], ab);
		flag_clr = 4'h8;
		tick(1);
		flag_clr = 4'h0;
		tick(1);
		chk(flags, CBS_FLAGS_RST);
		$display("test abort or retry done");
	endtask
	task automatic t_card(input logic b);
		int i;
		{card.bad, card.iadr, card.idat, card.ibe} = {b, 32'h0000_1F00, 32'h8421_7E5A, 4'h6};
		card.ngo++;
		for (i = 0; i < 300 && tgt_wr_valid !== 1'b1; i++)
			@(negedge core_clk);
		if (!b) begin
			chk(tgt_wr_addr, 32'h0000_1F00);
			chk(tgt_wr_data, 32'h8421_7E5A);
			chk(tgt_wr_be, 4'h6);
		end
		tick(20);
		card.bad = 0;
		chk(card.ndone, card.ngo);
		chk(gnt_n, 1);
		chk(flags[CBS_FLG_PERR], b);
		chk(card.perr > 0, b);
		flag_clr = 4'h1;
		tick(1);
		flag_clr = 4'h0;
		$display("test card write done");
	endtask
	task automatic t_side();
		{irq_n, sts, serr_n, audio_en, aud} = 5'b01011;
		{det1, det2, vs1, vs2, crun} = 5'b00100;
		tick(8);
		chk(card_irq, 1);
		chk({flags[CBS_FLG_STS], wake_event}, 2'b11);
		chk({flags[CBS_FLG_SERR], host_serr_n}, 2'b10);
		chk(speaker_out, 1);
		chk({card_present, card_sense}, 5'b10100);
		chk(card_clk_req, 1);
		{irq_n, sts, serr_n, aud, crun, clk_slow_req} = 6'b101011;
		flag_clr = 4'h6;
		tick(1);
		flag_clr = 4'h0;
		tick(8);
		chk({flags, host_serr_n, speaker_out, card_irq}, 7'b0000100);
		chk({d_ce, d_co}, 2'b11);
		sock_rst_req = 1;
		tick(20);
		chk(sock_reset_n, 0);
		{sock_rst_req, clk_slow_req} = 2'b00;
		tick(20);
		chk(sock_reset_n, 1);
		$display("test sideband done");
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		tick(10);
		chk({sock_reset_n, host_serr_n, d_ade}, 3'b011);
		rst_b = 1;
		tick(20);
		chk(sock_reset_n, 1);
		t_write();
		t_read();
		t_fail(1);
		t_fail(0);
		t_card(0);
		t_card(1);
		t_side();
		print_verdict();
	end
	initial begin
		#200us;
		err_count++;
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
